//--- design/rcw_ctrl.sv
// reset cause recorder, debug force reset, write-once options and watchdog
//
// Notes on behaviour
// - reset cause register is read-only; reset events load its flags
// - a debug forced reset leaves all cause flags clear
// - any write to the cause register restarts the watchdog, flags kept
// - power-up reset sets bit 7 and bit 1, clears the rest
// - undervoltage reset keeps bit 7, sets bit 1, clears the rest
// - other resets flag each active source, clear bits 7 and 1
// - bit 6 flags a reset from a low external reset pin
// - bit 5 flags a watchdog overflow reset; blocked when reset allow is 0
// - bad opcode, or halt while halt not allowed, resets and sets bit 4
// - debug halt with debug mode not allowed is a bad opcode reset
// - bit 2 flags a reset caused by loss of the external clock
// - enabled undervoltage detect, with reset or stop enable set, below trip level resets, sets bit 1
// - user program writes to force-reset register are ignored
// - force-reset register always reads zero
// - debug host writing 1 to bit 0 forces a full reset
// - options register always readable; bits 3 and 2 read zero
// - options register takes only the first write after each reset
// - halt allow resets to 0; halt while 0 gives bad opcode reset
// - period 0:0 disables; slow source overflows after 32, 256, 1024
// - bus source overflows after 2^13, 2^16, 2^18 cycles
// - window mode on the bus source restarts only in the last quarter of the period
// - source select 0 is the 1 kHz oscillator, 1 the bus clock
// - window mode on the bus source: cause register write in first 75% resets device
`timescale 1ns/1ps
module rcw_ctrl import rcw_pkg::*; #(
  parameter int unsigned WD_CNT_W = 18
) (
  // clock and power-up reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // user program register port
  input wire logic [1:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_wdata_i,
  // serial background debug register port
  input wire logic [1:0] dbg_addr_i,
  input wire logic dbg_wr_i,
  input wire logic dbg_rd_i,
  input wire logic [7:0] dbg_wdata_i,
  // read data, shared by both ports
  output logic [7:0] rdata_o,
  // asynchronous reset sources (pins and analog detectors) and the slow oscillator
  input wire logic ext_reset_n_i,
  input wire logic osc_lost_i,
  input wire logic uv_below_i,
  input wire logic slow_osc_1khz_i,
  // configuration from neighbouring logic
  input wire logic uv_detect_en_i,
  input wire logic undervoltage_reset_enable_i,
  input wire logic undervoltage_stop_enable_i,
  input wire logic watchdog_reset_allow_i,
  input wire logic watchdog_source_select_i,
  input wire logic watchdog_window_mode_i,
  input wire logic debug_mode_allow_i,
  // instruction events from the processor
  input wire logic opcode_bad_i,
  input wire logic halt_exec_i,
  input wire logic debug_halt_exec_i,
  // outputs
  output logic sys_reset_o,
  output logic halt_grant_o,
  output logic debug_halt_grant_o
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (RST_HOLD_CYC < 1 || RST_HOLD_CYC >= (1 << HOLD_CNT_W)) begin : g_chk
    $error("rcw_ctrl: reset hold count does not fit its counter");
  end

  function automatic logic reg_hit(input logic [1:0] addr, input logic [1:0] idx);
    return addr == idx;
  endfunction

  // ---------------------------------------------------------------
  // synchronisers for pin and analog inputs
  // ---------------------------------------------------------------
  // order: slow osc, undervoltage, osc lost, reset pin (idles high)
  localparam logic [3:0] SYNC_RST = 4'h1;
  wire [3:0] async_in = {slow_osc_1khz_i, uv_below_i, osc_lost_i, ext_reset_n_i};
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic slow_prev;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
      slow_prev <= 1'b0;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
      slow_prev <= sync_b[3];
    end
  end

  wire pin_n_s = sync_b[0];
  wire osc_lost_s = sync_b[1];
  wire uv_below_s = sync_b[2];
  // edge of the slow oscillator, seen on the synchronised copy only
  wire slow_tick = sync_b[3] & ~slow_prev;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rcw_state_e state;
  rcw_state_e next_state;
  logic [HOLD_CNT_W-1:0] hold_cnt;
  logic [HOLD_CNT_W-1:0] next_hold_cnt;
  logic [7:0] cause;
  logic [7:0] next_cause;
  logic [7:0] opts;
  logic opts_locked;
  logic wd_overflow;
  logic wd_win_closed;

  wire running = (state == RCW_RUN);
  wire [1:0] wd_period = opts[OPT_PERIOD_LSB +: 2];
  wire halt_allow = opts[OPT_HALT_BIT];

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  // debug wins when both ports write in one cycle; software and the
  // debug host are not expected to race, so no arbitration beyond this
  wire wr_any = cpu_wr_i | dbg_wr_i;
  wire [1:0] wr_addr = dbg_wr_i ? dbg_addr_i : cpu_addr_i;
  wire [7:0] wr_data = dbg_wr_i ? dbg_wdata_i : cpu_wdata_i;
  wire rd_any = cpu_rd_i | dbg_rd_i;
  wire [1:0] rd_addr = dbg_rd_i ? dbg_addr_i : cpu_addr_i;

  // data of a cause write is dropped, only the address matters
  wire cause_wr = wr_any & reg_hit(wr_addr, IDX_CAUSE);
  wire opts_wr = wr_any & reg_hit(wr_addr, IDX_OPTS) & ~opts_locked;
  // the user port never reaches the force bit
  wire force_req = dbg_wr_i & reg_hit(dbg_addr_i, IDX_FORCE) & dbg_wdata_i[FORCE_BIT];

  wire [7:0] rd_value =
    reg_hit(rd_addr, IDX_CAUSE) ? cause :
    reg_hit(rd_addr, IDX_FORCE) ? FORCE_READ_VAL :
    reg_hit(rd_addr, IDX_OPTS) ? (opts & OPTS_IMPL_MASK) :
    8'h00;

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  wire src_pin = ~pin_n_s;
  // early restart in window mode counts as a watchdog failure
  wire win_violation = cause_wr & wd_win_closed;
  wire src_wdog = (wd_overflow & watchdog_reset_allow_i) | win_violation;
  wire bad_halt = halt_exec_i & ~halt_allow;
  wire bad_dbg_halt = debug_halt_exec_i & ~debug_mode_allow_i;
  wire src_badop = opcode_bad_i | bad_halt | bad_dbg_halt;
  wire src_osc = osc_lost_s;
  wire uv_armed = uv_detect_en_i & (undervoltage_reset_enable_i | undervoltage_stop_enable_i);
  wire src_uv = uv_armed & uv_below_s;
  wire any_src = src_pin | src_wdog | src_badop | src_osc | src_uv | force_req;
  // a pin held low or a supply still below trip keeps the chip in reset
  wire keep_hold = src_pin | src_uv;

  // ---------------------------------------------------------------
  // cause capture and sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_cause = cause;
    case (state)
      RCW_RUN: begin
        if (any_src) begin
          next_state = RCW_HOLD;
          next_hold_cnt = HOLD_CNT_W'(RST_HOLD_CYC - 1);
          if (src_uv) begin
            next_cause = (cause & (8'h01 << CAUSE_POR_BIT)) | (8'h01 << CAUSE_UV_BIT);
          end else begin
            // a debug forced reset adds no flag of its own
            next_cause = 8'h00;
            next_cause[CAUSE_PIN_BIT] = src_pin;
            next_cause[CAUSE_WDOG_BIT] = src_wdog;
            next_cause[CAUSE_BADOP_BIT] = src_badop;
            next_cause[CAUSE_OSC_BIT] = src_osc;
          end
        end
      end
      RCW_HOLD: begin
        if (hold_cnt != '0) begin
          next_hold_cnt = hold_cnt - HOLD_CNT_W'(1);
        end else if (!keep_hold) begin
          next_state = RCW_RUN;
        end
      end
      default: begin
        next_state = RCW_HOLD;
        next_hold_cnt = HOLD_CNT_W'(RST_HOLD_CYC - 1);
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= RCW_HOLD;
      hold_cnt <= HOLD_CNT_W'(RST_HOLD_CYC - 1);
      cause <= CAUSE_POR_VAL;
      sys_reset_o <= 1'b1;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      cause <= next_cause;
      sys_reset_o <= (next_state == RCW_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // write-once options
  // ---------------------------------------------------------------
  // any chip reset reopens the single write, as software expects to
  // write the options again during its initialization
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opts <= OPTS_RESET;
      opts_locked <= 1'b0;
    end else if (!running) begin
      opts <= OPTS_RESET;
      opts_locked <= 1'b0;
    end else if (opts_wr) begin
      opts <= wr_data & OPTS_IMPL_MASK;
      opts_locked <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read data and instruction grants
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
      halt_grant_o <= 1'b0;
      debug_halt_grant_o <= 1'b0;
    end else begin
      if (rd_any) begin
        rdata_o <= rd_value;
      end
      halt_grant_o <= running & halt_exec_i & halt_allow & ~any_src;
      debug_halt_grant_o <= running & debug_halt_exec_i & debug_mode_allow_i & ~any_src;
    end
  end

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  wire wd_restart = ~running | cause_wr;

  rcw_wdog #(
    .CNT_W(WD_CNT_W)
  ) u_wdog (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .restart_i(wd_restart),
    .period_i(wd_period),
    .src_bus_i(watchdog_source_select_i),
    .window_i(watchdog_window_mode_i),
    .slow_tick_i(slow_tick),
    .overflow_o(wd_overflow),
    .win_closed_o(wd_win_closed)
  );

endmodule // rcw_ctrl

//--- shared/rcw_pkg.sv
// constants and types shared by the reset cause and watchdog control block
package rcw_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 50;
  // minimum width of the chip reset pulse, in ns
  localparam int unsigned RST_HOLD_NS = 1000;
  // least time, so round up to whole cycles
  localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_CNT_W = 8;

  // ---------------------------------------------------------------
  // register indexes on the register port
  // ---------------------------------------------------------------
  localparam logic [1:0] IDX_CAUSE = 2'h0;
  localparam logic [1:0] IDX_FORCE = 2'h1;
  localparam logic [1:0] IDX_OPTS = 2'h2;

  // ---------------------------------------------------------------
  // reset cause register fields
  // ---------------------------------------------------------------
  localparam int unsigned CAUSE_POR_BIT = 7;
  localparam int unsigned CAUSE_PIN_BIT = 6;
  localparam int unsigned CAUSE_WDOG_BIT = 5;
  localparam int unsigned CAUSE_BADOP_BIT = 4;
  localparam int unsigned CAUSE_OSC_BIT = 2;
  localparam int unsigned CAUSE_UV_BIT = 1;
  localparam logic [7:0] CAUSE_POR_VAL = 8'h82;

  // ---------------------------------------------------------------
  // debug force-reset register fields
  // ---------------------------------------------------------------
  localparam int unsigned FORCE_BIT = 0;
  localparam logic [7:0] FORCE_READ_VAL = 8'h00;

  // ---------------------------------------------------------------
  // system options register fields
  // ---------------------------------------------------------------
  localparam int unsigned OPT_PERIOD_LSB = 6;
  localparam int unsigned OPT_HALT_BIT = 5;
  localparam logic [7:0] OPTS_IMPL_MASK = 8'hf3;
  localparam logic [7:0] OPTS_RESET = 8'hc0;

  // ---------------------------------------------------------------
  // watchdog periods, as powers of two
  // ---------------------------------------------------------------
  localparam logic [1:0] WD_PERIOD_OFF = 2'h0;
  localparam logic [4:0] WD_SLOW_EXP_S = 5'h05;
  localparam logic [4:0] WD_SLOW_EXP_M = 5'h08;
  localparam logic [4:0] WD_SLOW_EXP_L = 5'h0a;
  localparam logic [4:0] WD_BUS_EXP_S = 5'h0d;
  localparam logic [4:0] WD_BUS_EXP_M = 5'h10;
  localparam logic [4:0] WD_BUS_EXP_L = 5'h12;

  // ---------------------------------------------------------------
  // reset sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    RCW_RUN = 1'b0,
    RCW_HOLD = 1'b1
  } rcw_state_e;

endpackage

//--- design/rcw_wdog.sv
// watchdog counter with selectable source, period and window
`timescale 1ns/1ps
module rcw_wdog import rcw_pkg::*; #(
  parameter int unsigned CNT_W = 18
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // control
  input wire logic restart_i,
  input wire logic [1:0] period_i,
  input wire logic src_bus_i,
  input wire logic window_i,
  input wire logic slow_tick_i,
  // status
  output logic overflow_o,
  output logic win_closed_o
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (CNT_W < 32'(WD_BUS_EXP_L)) begin : g_chk
    $error("rcw_wdog: CNT_W too small for the longest period");
  end

  function automatic logic [4:0] wd_exp(input logic [1:0] sel, input logic bus);
    logic [4:0] e;
    e = 5'h00;
    case (sel)
      2'h1: e = bus ? WD_BUS_EXP_S : WD_SLOW_EXP_S;
      2'h2: e = bus ? WD_BUS_EXP_M : WD_SLOW_EXP_M;
      2'h3: e = bus ? WD_BUS_EXP_L : WD_SLOW_EXP_L;
      default: e = 5'h00;
    endcase
    return e;
  endfunction

  // ---------------------------------------------------------------
  // count decode
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] count;
  wire enabled = (period_i != WD_PERIOD_OFF);
  wire tick = src_bus_i | slow_tick_i;
  wire [CNT_W:0] limit = (CNT_W + 1)'(1) << wd_exp(period_i, src_bus_i);
  wire [CNT_W:0] last = limit - (CNT_W + 1)'(1);
  // window opens at three quarters of the period
  wire [CNT_W:0] win_open = limit - (limit >> 2);
  // not equality: a shorter period chosen late must still overflow
  wire at_last = ({1'b0, count} >= last);

  assign win_closed_o = enabled & window_i & src_bus_i & ({1'b0, count} < win_open);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= 1'b0;
      if (restart_i || !enabled) begin
        count <= '0;
      end else if (tick) begin
        if (at_last) begin
          count <= '0;
          overflow_o <= 1'b1;
        end else begin
          count <= count + (CNT_W)'(1);
        end
      end
    end
  end

endmodule // rcw_wdog

//--- testbench/rcw_ctrl_properties.sv
// port-level assertions for the reset cause and watchdog control block
`timescale 1ns/1ps
module rcw_ctrl_chk import rcw_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // register ports
  input wire logic [1:0] cpu_addr_i,
  input wire logic cpu_rd_i,
  input wire logic [1:0] dbg_addr_i,
  input wire logic dbg_wr_i,
  input wire logic dbg_rd_i,
  input wire logic [7:0] dbg_wdata_i,
  input wire logic [7:0] rdata_o,
  // reset sources and events
  input wire logic ext_reset_n_i,
  input wire logic osc_lost_i,
  input wire logic uv_below_i,
  input wire logic uv_detect_en_i,
  input wire logic undervoltage_reset_enable_i,
  input wire logic undervoltage_stop_enable_i,
  input wire logic debug_mode_allow_i,
  input wire logic opcode_bad_i,
  input wire logic debug_halt_exec_i,
  // outputs
  input wire logic sys_reset_o,
  input wire logic debug_halt_grant_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] hold_cnt;
  logic rd_go;
  logic [1:0] rd_idx;
  logic uv_armed;
  assign rd_go = (cpu_rd_i || dbg_rd_i) && !sys_reset_o;
  // debug port wins when both ports read together
  assign rd_idx = dbg_rd_i ? dbg_addr_i : cpu_addr_i;
  assign uv_armed = uv_detect_en_i && (undervoltage_reset_enable_i || undervoltage_stop_enable_i);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_cnt <= 8'h00;
    end else if (!sys_reset_o) begin
      hold_cnt <= 8'h00;
    end else if (hold_cnt != 8'hff) begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  hold_length_a: assert property ($fell(sys_reset_o) |-> hold_cnt >= RST_HOLD_CYC - 1)
    else $error("chip reset released too early");
  bad_opcode_a: assert property (opcode_bad_i && !sys_reset_o |=> sys_reset_o)
    else $error("bad opcode did not reset");
  debug_halt_deny_a: assert property (debug_halt_exec_i && !debug_mode_allow_i && !sys_reset_o
    |=> sys_reset_o && !debug_halt_grant_o) else $error("debug halt not refused");
  debug_halt_ok_a: assert property (debug_halt_exec_i && debug_mode_allow_i && !sys_reset_o
    |=> debug_halt_grant_o) else $error("debug halt not granted");
  force_reset_a: assert property (dbg_wr_i && dbg_addr_i == IDX_FORCE && dbg_wdata_i[FORCE_BIT]
    && !sys_reset_o |=> sys_reset_o) else $error("debug force did not reset");
  force_zero_a: assert property (rd_go && rd_idx == IDX_FORCE |=> rdata_o == FORCE_READ_VAL)
    else $error("force register read not zero");
  opts_unused_a: assert property (rd_go && rd_idx == IDX_OPTS |=> rdata_o[3:2] == 2'h0)
    else $error("options bits 3:2 not zero");
  cause_unused_a: assert property (rd_go && rd_idx == IDX_CAUSE |=> !rdata_o[3] && !rdata_o[0])
    else $error("cause unused bits not zero");
  pin_reset_a: assert property (!ext_reset_n_i && !sys_reset_o
    |-> ##[1:5] (sys_reset_o || ext_reset_n_i)) else $error("reset pin ignored");
  osc_reset_a: assert property (osc_lost_i && !sys_reset_o
    |-> ##[1:5] (sys_reset_o || !osc_lost_i)) else $error("clock loss ignored");
  uv_reset_a: assert property (uv_armed && uv_below_i && !sys_reset_o
    |-> ##[1:5] (sys_reset_o || !uv_below_i)) else $error("undervoltage ignored");
  cover property (dbg_wr_i && dbg_addr_i == IDX_FORCE && dbg_wdata_i[FORCE_BIT] && !sys_reset_o);
  cover property (debug_halt_grant_o);
  cover property ($fell(sys_reset_o));
endmodule // rcw_ctrl_chk

bind rcw_ctrl rcw_ctrl_chk u_chk (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i),
  .dbg_addr_i(dbg_addr_i), .dbg_wr_i(dbg_wr_i), .dbg_rd_i(dbg_rd_i), .dbg_wdata_i(dbg_wdata_i),
  .rdata_o(rdata_o), .ext_reset_n_i(ext_reset_n_i), .osc_lost_i(osc_lost_i), .uv_below_i(uv_below_i),
  .uv_detect_en_i(uv_detect_en_i), .undervoltage_reset_enable_i(undervoltage_reset_enable_i),
  .undervoltage_stop_enable_i(undervoltage_stop_enable_i), .debug_mode_allow_i(debug_mode_allow_i),
  .opcode_bad_i(opcode_bad_i), .debug_halt_exec_i(debug_halt_exec_i), .sys_reset_o(sys_reset_o),
  .debug_halt_grant_o(debug_halt_grant_o)
);

//--- testbench/testbench.sv
// self-checking bench for the reset cause and watchdog control block
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h, expected %h", $time, g, e); \
  end \
end
module testbench import rcw_pkg::*; ;
  logic ref_clk_i, resetn_i, slow_osc, cpu_wr_i, cpu_rd_i, dbg_wr_i, dbg_rd_i;
  logic [1:0] cpu_addr_i, dbg_addr_i;
  logic [7:0] cpu_wdata_i, dbg_wdata_i, rdata_o;
  logic ext_reset_n_i, osc_lost_i, uv_below_i, uv_en, uv_rst_en, uv_stop_en;
  logic wd_allow, wd_src, wd_win, dbg_allow, opcode_bad_i, halt_exec_i, debug_halt_exec_i;
  logic sys_reset_o, halt_grant_o, debug_halt_grant_o, hg, dg;
  int miscompares = 0;
  int checks = 0;
  rcw_ctrl u_dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_wdata_i(cpu_wdata_i),
    .dbg_addr_i(dbg_addr_i), .dbg_wr_i(dbg_wr_i), .dbg_rd_i(dbg_rd_i), .dbg_wdata_i(dbg_wdata_i),
    .rdata_o(rdata_o), .ext_reset_n_i(ext_reset_n_i), .osc_lost_i(osc_lost_i), .uv_below_i(uv_below_i),
    .slow_osc_1khz_i(slow_osc), .uv_detect_en_i(uv_en), .undervoltage_reset_enable_i(uv_rst_en),
    .undervoltage_stop_enable_i(uv_stop_en), .watchdog_reset_allow_i(wd_allow),
    .watchdog_source_select_i(wd_src), .watchdog_window_mode_i(wd_win), .debug_mode_allow_i(dbg_allow),
    .opcode_bad_i(opcode_bad_i), .halt_exec_i(halt_exec_i), .debug_halt_exec_i(debug_halt_exec_i),
    .sys_reset_o(sys_reset_o), .halt_grant_o(halt_grant_o), .debug_halt_grant_o(debug_halt_grant_o)
  );
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // slow oscillator shortened to 8 clocks so watchdog runs stay short
  initial begin
    slow_osc = 1'b0;
    #11;
    forever #80 slow_osc = ~slow_osc;
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task bus(input bit dbg, input bit wr, input logic [1:0] a, input logic [7:0] d);
    if (dbg) begin
      {dbg_addr_i, dbg_wdata_i, dbg_wr_i, dbg_rd_i} = {a, d, wr, !wr};
    end else begin
      {cpu_addr_i, cpu_wdata_i, cpu_wr_i, cpu_rd_i} = {a, d, wr, !wr};
    end
    step(1);
    {cpu_wr_i, cpu_rd_i, dbg_wr_i, dbg_rd_i} = 4'h0;
    step(1);
  endtask
  task rd(input bit dbg, input logic [1:0] a, input logic [7:0] e);
    bus(dbg, 1'b0, a, 8'h00);
    `CHK(rdata_o, e)
  endtask
  task quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      step(1);
      seen = seen | sys_reset_o;
    end
    `CHK(seen, 1'b0)
  endtask
  task wait_run();
    for (int i = 0; i < 400 && sys_reset_o !== 1'b0; i++) begin
      step(1);
    end
    `CHK(sys_reset_o, 1'b0)
  endtask
  task expect_reset(input logic [7:0] e);
    for (int i = 0; i < 100 && sys_reset_o !== 1'b1; i++) begin
      step(1);
    end
    `CHK(sys_reset_o, 1'b1)
    wait_run();
    rd(1'b0, IDX_CAUSE, e);
  endtask
  // level sources: bit 0 pin low, bit 1 clock lost, bit 2 supply low
  task hold_src(input logic [2:0] m);
    {uv_below_i, osc_lost_i, ext_reset_n_i} = {m[2], m[1], !m[0]};
    step(6);
    {uv_below_i, osc_lost_i, ext_reset_n_i} = 3'h1;
  endtask
  task ev(input int k);
    case (k)
      0: opcode_bad_i = 1'b1;
      1: halt_exec_i = 1'b1;
      default: debug_halt_exec_i = 1'b1;
    endcase
    hg = 1'b0;
    dg = 1'b0;
    step(1);
    {opcode_bad_i, halt_exec_i, debug_halt_exec_i} = 3'h0;
    repeat (3) begin
      hg = hg | halt_grant_o;
      dg = dg | debug_halt_grant_o;
      step(1);
    end
  endtask
  task results();
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    results();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    {cpu_addr_i, cpu_wr_i, cpu_rd_i, cpu_wdata_i, dbg_addr_i, dbg_wr_i, dbg_rd_i, dbg_wdata_i} = '0;
    {osc_lost_i, uv_below_i, uv_en, uv_rst_en, uv_stop_en, wd_allow, wd_src, wd_win, dbg_allow} = '0;
    {opcode_bad_i, halt_exec_i, debug_halt_exec_i, ext_reset_n_i, resetn_i} = 5'h2;
    step(20);
    resetn_i = 1'b1;
    wait_run();
    rd(1'b0, IDX_CAUSE, CAUSE_POR_VAL);
    rd(1'b0, IDX_OPTS, OPTS_RESET);
    rd(1'b1, IDX_FORCE, FORCE_READ_VAL);
    rd(1'b0, 2'h3, 8'h00);
    {uv_en, uv_rst_en} = 2'h3;
    hold_src(3'h4);
    expect_reset(CAUSE_POR_VAL);
    uv_rst_en = 1'b0;
    bus(1'b0, 1'b1, IDX_CAUSE, 8'hff);
    rd(1'b1, IDX_CAUSE, CAUSE_POR_VAL);
    bus(1'b0, 1'b1, IDX_FORCE, 8'h01);
    quiet(60);
    bus(1'b1, 1'b1, IDX_FORCE, 8'hfe);
    quiet(60);
    rd(1'b1, IDX_FORCE, FORCE_READ_VAL);
    bus(1'b0, 1'b1, IDX_OPTS, 8'h7f);
    rd(1'b0, IDX_OPTS, 8'h73);
    bus(1'b0, 1'b1, IDX_OPTS, 8'h00);
    rd(1'b1, IDX_OPTS, 8'h73);
    ev(1);
    `CHK(hg, 1'b1)
    quiet(10);
    bus(1'b1, 1'b1, IDX_FORCE, 8'h01);
    expect_reset(8'h00);
    rd(1'b0, IDX_OPTS, OPTS_RESET);
    ev(1);
    `CHK(hg, 1'b0)
    expect_reset(8'h10);
    ev(0);
    expect_reset(8'h10);
    dbg_allow = 1'b1;
    ev(2);
    `CHK(dg, 1'b1)
    dbg_allow = 1'b0;
    ev(2);
    expect_reset(8'h10);
    hold_src(3'h1);
    expect_reset(8'h40);
    hold_src(3'h2);
    expect_reset(8'h04);
    hold_src(3'h3);
    expect_reset(8'h44);
    uv_stop_en = 1'b1;
    hold_src(3'h4);
    expect_reset(8'h02);
    uv_en = 1'b0;
    hold_src(3'h4);
    quiet(60);
    // watchdog on the slow source, shortest period
    bus(1'b0, 1'b1, IDX_OPTS, 8'h40);
    quiet(400);
    bus(1'b0, 1'b1, IDX_CAUSE, 8'h00);
    wd_allow = 1'b1;
    quiet(200);
    bus(1'b0, 1'b1, IDX_CAUSE, 8'h55);
    quiet(240);
    expect_reset(8'h20);
    // middle slow period: 256 ticks of 8 clocks each
    bus(1'b0, 1'b1, IDX_OPTS, 8'h80);
    bus(1'b0, 1'b1, IDX_CAUSE, 8'h00);
    quiet(2030);
    expect_reset(8'h20);
    bus(1'b0, 1'b1, IDX_OPTS, 8'h00);
    quiet(400);
    // watchdog on the bus clock, then window mode
    wd_src = 1'b1;
    bus(1'b1, 1'b1, IDX_FORCE, 8'h01);
    expect_reset(8'h00);
    bus(1'b0, 1'b1, IDX_OPTS, 8'h40);
    bus(1'b0, 1'b1, IDX_CAUSE, 8'h00);
    quiet(8150);
    expect_reset(8'h20);
    bus(1'b0, 1'b1, IDX_OPTS, 8'h40);
    wd_win = 1'b1;
    quiet(6300);
    bus(1'b0, 1'b1, IDX_CAUSE, 8'h00);
    quiet(1000);
    bus(1'b0, 1'b1, IDX_CAUSE, 8'h00);
    expect_reset(8'h20);
    wd_win = 1'b0;
    // power-up reset again in mid-run
    resetn_i = 1'b0;
    step(2);
    resetn_i = 1'b1;
    wait_run();
    rd(1'b0, IDX_CAUSE, CAUSE_POR_VAL);
    results();
  end
endmodule // testbench
